//--- rtl/mdp_defs.svh
// Constants of the motion digital I/O, pulse-width and trigger router block.
// Assumes a single 25 MHz clock and a byte-addressed register port.
`ifndef MDP_DEFS_SVH
`define MDP_DEFS_SVH

`define MDP_OFS_PORT_DATA  8'h00
`define MDP_OFS_PORT_DIR   8'h08
`define MDP_OFS_PORT_POL   8'h10
`define MDP_OFS_HALL_CFG   8'h20
`define MDP_OFS_REINIT     8'h21
`define MDP_OFS_HALL_STAT  8'h22
`define MDP_OFS_PULSE_WIDTH_OUT_ONE_PER   8'h30
`define MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY  8'h31
`define MDP_OFS_PULSE_WIDTH_OUT_TWO_PER   8'h32
`define MDP_OFS_PULSE_WIDTH_OUT_TWO_DUTY  8'h33
`define MDP_OFS_PWM_CLK    8'h34
`define MDP_OFS_TRIG_MODE  8'h40
`define MDP_OFS_TRIG_SEL   8'h41
`define MDP_OFS_TRIG_DOUT  8'h42
`define MDP_OFS_TRIG_DIR   8'h43
`define MDP_OFS_TRIG_STAT  8'h44
`define MDP_OFS_DRV_MODE   8'h50
`define MDP_OFS_PULL_STAT  8'h51

`define MDP_HALL_LSB       2
`define MDP_HALL_PORT_A    3
`define MDP_HALL_PORT_B    7
`define MDP_RST_PULL       2'h3

`define MDP_CLK_NS         40
`define MDP_BP_PULSE_NS    200
`define MDP_BP_CYC         ((`MDP_BP_PULSE_NS + `MDP_CLK_NS - 1) / `MDP_CLK_NS)

`endif

//--- rtl/mdp_pkg.sv
// Types shared by the motion digital I/O router.
// Assumes the constants header is included by the design file.
package mdp_pkg;

  typedef enum logic [1:0] {
    MDP_TRG_CAPTURE_IN,
    MDP_TRG_BREAKPOINT_OUT,
    MDP_TRG_ENCODER_OUT,
    MDP_TRG_GENERIC_DIO
  } mdp_trig_mode_t;

endpackage : mdp_pkg

//--- rtl/mdp_router.sv
// General I/O ports, Hall takeover, pulse-width outputs and trigger routing.
// Assumes one clock, a synchronous active-low reset and a strobe register port.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "mdp_defs.svh"

module mdp_router
  import mdp_pkg::*;
#(
  parameter int PWM_W    = 16,
  parameter int NUM_AXES = 8
) (
  input  wire logic                clock_in,
  input  wire logic                rst_n_in,
  input  wire logic [7:0]          addr_in,
  input  wire logic [31:0]         wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [31:0]         rdata_out,
  input  wire logic [63:0]         gpio_in,
  output logic      [63:0]         gpio_out,
  output logic      [63:0]         gpio_oe_out,
  input  wire logic [1:0]          power_up_pull_select_in,
  output logic      [1:0]          pull_up_out,
  output logic      [11:0]         hall_out,
  input  wire logic                pwm_ext_clk_in,
  output logic                     pulse_width_out_one_out,
  output logic                     pulse_width_out_two_out,
  input  wire logic [7:0]          sync_trigger_bus_in,
  output logic      [7:0]          sync_trigger_bus_out,
  output logic      [7:0]          sync_trigger_bus_oe_out,
  input  wire logic                star_trigger_in,
  output logic      [7:0]          capture_trigger_out,
  output logic                     star_capture_out,
  input  wire logic [7:0]          breakpoint_event_in,
  input  wire logic [7:0]          encoder_filtered_in,
  input  wire logic [NUM_AXES-1:0] step_gen_in,
  input  wire logic [NUM_AXES-1:0] dir_gen_in,
  output logic      [NUM_AXES-1:0] step_out,
  output logic      [NUM_AXES-1:0] step_oe_out,
  output logic      [NUM_AXES-1:0] dir_out,
  output logic      [NUM_AXES-1:0] dir_oe_out
);

  if (PWM_W < 2 || PWM_W > 32) begin : g_chk_pwm
    $error("PWM_W must lie between 2 and 32.");
  end
  if (NUM_AXES < 1 || NUM_AXES > 32) begin : g_chk_axes
    $error("NUM_AXES must lie between 1 and 32.");
  end

  localparam logic [2:0] BP_CYC = 3'(`MDP_BP_CYC);
  localparam logic [7:0] OFS_DATA = `MDP_OFS_PORT_DATA;
  localparam logic [7:0] OFS_DIR  = `MDP_OFS_PORT_DIR;
  localparam logic [7:0] OFS_POL  = `MDP_OFS_PORT_POL;

  logic        cfg_clr;
  logic        wr_data;
  logic        wr_dir;
  logic        wr_pol;
  logic [5:0]  lane;
  logic [63:0] out_reg;
  logic [63:0] dir_reg;
  logic [63:0] pol_reg;
  logic [3:0]  hall_reg;
  logic [63:0] hall_mask;
  logic [63:0] gpio_s1_reg;
  logic [63:0] gpio_s2_reg;
  logic [63:0] port_view;
  logic [1:0]  pull_s1_reg;
  logic [1:0]  pull_s2_reg;
  logic        pull_taken_reg;

  // A write to the reinit offset clears the port and Hall configuration like a reset.
  assign cfg_clr = !rst_n_in || (wr_in && addr_in == `MDP_OFS_REINIT);
  assign wr_data = wr_in && addr_in[7:3] == OFS_DATA[7:3];
  assign wr_dir  = wr_in && addr_in[7:3] == OFS_DIR[7:3];
  assign wr_pol  = wr_in && addr_in[7:3] == OFS_POL[7:3];
  assign lane    = {addr_in[2:0], 3'h0};

  // Port bytes are addressed as whole bytes, one bit per line.
  always_ff @(posedge clock_in) begin
    if (cfg_clr) begin
      out_reg <= '0;
      dir_reg <= '0;
      pol_reg <= '0;
    end else begin
      if (wr_data) begin
        out_reg[lane +: 8] <= wdata_in[7:0];
      end
      if (wr_dir) begin
        dir_reg[lane +: 8] <= wdata_in[7:0];
      end
      if (wr_pol) begin
        pol_reg[lane +: 8] <= wdata_in[7:0];
      end
    end
  end

  // Hall assignment bits only set; they clear by reset or reinit alone.
  always_ff @(posedge clock_in) begin
    if (cfg_clr) begin
      hall_reg <= 4'h0;
    end else if (wr_in && addr_in == `MDP_OFS_HALL_CFG) begin
      hall_reg <= hall_reg | wdata_in[3:0];
    end
  end

  always_comb begin
    hall_mask = '0;
    hall_mask[`MDP_HALL_PORT_A*8+`MDP_HALL_LSB +: 3]     = {3{hall_reg[0]}};
    hall_mask[`MDP_HALL_PORT_A*8+`MDP_HALL_LSB + 3 +: 3] = {3{hall_reg[1]}};
    hall_mask[`MDP_HALL_PORT_B*8+`MDP_HALL_LSB +: 3]     = {3{hall_reg[2]}};
    hall_mask[`MDP_HALL_PORT_B*8+`MDP_HALL_LSB + 3 +: 3] = {3{hall_reg[3]}};
  end

  always_ff @(posedge clock_in) begin
    gpio_s1_reg <= gpio_in;
    gpio_s2_reg <= gpio_s1_reg;
  end

  assign port_view = (gpio_s2_reg ^ pol_reg) & ~hall_mask;

  // Lines given to Hall feedback are never driven by the general logic.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gpio_out    <= '0;
      gpio_oe_out <= '0;
      hall_out    <= 12'h000;
    end else begin
      gpio_out    <= (out_reg ^ pol_reg) & ~hall_mask;
      gpio_oe_out <= dir_reg & ~hall_mask;
      hall_out    <= {gpio_s2_reg[`MDP_HALL_PORT_B*8+`MDP_HALL_LSB +: 6] &
                      hall_mask[`MDP_HALL_PORT_B*8+`MDP_HALL_LSB +: 6],
                      gpio_s2_reg[`MDP_HALL_PORT_A*8+`MDP_HALL_LSB +: 6] &
                      hall_mask[`MDP_HALL_PORT_A*8+`MDP_HALL_LSB +: 6]};
    end
  end

  // Pull direction is caught once, on the first edge after reset release.
  always_ff @(posedge clock_in) begin
    pull_s1_reg <= power_up_pull_select_in;
    pull_s2_reg <= pull_s1_reg;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pull_up_out    <= `MDP_RST_PULL;
      pull_taken_reg <= 1'b0;
    end else if (!pull_taken_reg) begin
      pull_up_out    <= pull_s2_reg;
      pull_taken_reg <= 1'b1;
    end
  end

  // Pulse-width generators.
  logic [PWM_W-1:0] per_reg  [2];
  logic [PWM_W-1:0] duty_reg [2];
  logic [PWM_W-1:0] cnt_reg  [2];
  logic [1:0]       pwm_lvl;
  logic             pwm_ext_reg;
  logic             pclk_s1_reg;
  logic             pclk_s2_reg;
  logic             pclk_s3_reg;
  logic             pwm_tick;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      per_reg[0]  <= '0;
      per_reg[1]  <= '0;
      duty_reg[0] <= '0;
      duty_reg[1] <= '0;
      pwm_ext_reg <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_PER:  per_reg[0]  <= wdata_in[PWM_W-1:0];
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY: duty_reg[0] <= wdata_in[PWM_W-1:0];
        `MDP_OFS_PULSE_WIDTH_OUT_TWO_PER:  per_reg[1]  <= wdata_in[PWM_W-1:0];
        `MDP_OFS_PULSE_WIDTH_OUT_TWO_DUTY: duty_reg[1] <= wdata_in[PWM_W-1:0];
        `MDP_OFS_PWM_CLK:   pwm_ext_reg <= wdata_in[0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    pclk_s1_reg <= pwm_ext_clk_in;
    pclk_s2_reg <= pclk_s1_reg;
    pclk_s3_reg <= pclk_s2_reg;
  end

  assign pwm_tick = pwm_ext_reg ? (pclk_s2_reg && !pclk_s3_reg) : 1'b1;

  for (genvar c = 0; c < 2; c++) begin : g_pwm
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        cnt_reg[c] <= '0;
      end else if (pwm_tick) begin
        if (cnt_reg[c] + 1'b1 >= per_reg[c]) begin
          cnt_reg[c] <= '0;
        end else begin
          cnt_reg[c] <= cnt_reg[c] + 1'b1;
        end
      end
    end

    always_comb begin
      if (duty_reg[c] == '0) begin
        pwm_lvl[c] = 1'b0;
      end else if (duty_reg[c] >= per_reg[c]) begin
        pwm_lvl[c] = 1'b1;
      end else begin
        pwm_lvl[c] = cnt_reg[c] < duty_reg[c];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pulse_width_out_one_out <= 1'b0;
      pulse_width_out_two_out <= 1'b0;
    end else begin
      pulse_width_out_one_out <= pwm_lvl[0];
      pulse_width_out_two_out <= pwm_lvl[1];
    end
  end

  // Trigger bus routing.
  logic [15:0] trig_mode_reg;
  logic [23:0] trig_sel_reg;
  logic [7:0]  tdio_out_reg;
  logic [7:0]  tdio_dir_reg;
  logic [7:0]  trig_s1_reg;
  logic [7:0]  trig_s2_reg;
  logic        star_s1_reg;
  logic        star_s2_reg;
  logic [2:0]  bp_cnt_reg [8];
  logic [2:0]  bp_cnt_next [8];
  logic [7:0]  trig_lvl;
  logic [7:0]  trig_oe;
  logic [7:0]  cap_lvl;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      trig_mode_reg <= 16'h0000;
      trig_sel_reg  <= 24'h000000;
      tdio_out_reg  <= 8'h00;
      tdio_dir_reg  <= 8'h00;
    end else if (wr_in) begin
      case (addr_in)
        `MDP_OFS_TRIG_MODE: trig_mode_reg <= wdata_in[15:0];
        `MDP_OFS_TRIG_SEL:  trig_sel_reg  <= wdata_in[23:0];
        `MDP_OFS_TRIG_DOUT: tdio_out_reg  <= wdata_in[7:0];
        `MDP_OFS_TRIG_DIR:  tdio_dir_reg  <= wdata_in[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    trig_s1_reg <= sync_trigger_bus_in;
    trig_s2_reg <= trig_s1_reg;
    star_s1_reg <= star_trigger_in;
    star_s2_reg <= star_s1_reg;
  end

  for (genvar i = 0; i < 8; i++) begin : g_trig
    mdp_trig_mode_t mode;
    logic [2:0]     sel;

    assign mode = mdp_trig_mode_t'(trig_mode_reg[2*i +: 2]);
    assign sel  = trig_sel_reg[3*i +: 3];

    always_comb begin
      bp_cnt_next[i] = bp_cnt_reg[i];
      if (mode == MDP_TRG_BREAKPOINT_OUT && breakpoint_event_in[sel]) begin
        bp_cnt_next[i] = BP_CYC;
      end else if (bp_cnt_reg[i] != 3'h0) begin
        bp_cnt_next[i] = bp_cnt_reg[i] - 3'h1;
      end
    end

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        bp_cnt_reg[i] <= 3'h0;
      end else begin
        bp_cnt_reg[i] <= bp_cnt_next[i];
      end
    end

    always_comb begin
      trig_lvl[i] = 1'b0;
      trig_oe[i]  = 1'b0;
      cap_lvl[i]  = 1'b0;
      case (mode)
        MDP_TRG_CAPTURE_IN: begin
          cap_lvl[i] = trig_s2_reg[i];
        end
        MDP_TRG_BREAKPOINT_OUT: begin
          trig_lvl[i] = bp_cnt_next[i] != 3'h0;
          trig_oe[i]  = 1'b1;
        end
        MDP_TRG_ENCODER_OUT: begin
          trig_lvl[i] = encoder_filtered_in[sel];
          trig_oe[i]  = 1'b1;
        end
        MDP_TRG_GENERIC_DIO: begin
          trig_lvl[i] = tdio_out_reg[i];
          trig_oe[i]  = tdio_dir_reg[i];
        end
        default: begin
        end
      endcase
    end
  end

  // The star line has no driver at all; it only feeds capture and the trigger status read-back.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync_trigger_bus_out    <= 8'h00;
      sync_trigger_bus_oe_out <= 8'h00;
      capture_trigger_out     <= 8'h00;
      star_capture_out        <= 1'b0;
    end else begin
      sync_trigger_bus_out    <= trig_lvl;
      sync_trigger_bus_oe_out <= trig_oe;
      capture_trigger_out     <= cap_lvl;
      star_capture_out        <= star_s2_reg;
    end
  end

  // Step and direction drivers.
  logic [NUM_AXES-1:0] oc_reg;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      oc_reg <= '0;
    end else if (wr_in && addr_in == `MDP_OFS_DRV_MODE) begin
      oc_reg <= wdata_in[NUM_AXES-1:0];
    end
  end

  // Open collector only pulls low, so a high level releases the pin.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      step_out    <= '0;
      step_oe_out <= '0;
      dir_out     <= '0;
      dir_oe_out  <= '0;
    end else begin
      step_out    <= step_gen_in & ~oc_reg;
      step_oe_out <= ~(oc_reg & step_gen_in);
      dir_out     <= dir_gen_in & ~oc_reg;
      dir_oe_out  <= ~(oc_reg & dir_gen_in);
    end
  end

  // Register read-back.
  logic [31:0] rd_next;

  always_comb begin
    rd_next = 32'h00000000;
    if (addr_in[7:3] == OFS_DATA[7:3]) begin
      rd_next = {24'h000000, port_view[lane +: 8]};
    end else if (addr_in[7:3] == OFS_DIR[7:3]) begin
      rd_next = {24'h000000, dir_reg[lane +: 8]};
    end else if (addr_in[7:3] == OFS_POL[7:3]) begin
      rd_next = {24'h000000, pol_reg[lane +: 8]};
    end else begin
      case (addr_in)
        `MDP_OFS_HALL_CFG:  rd_next = {28'h0000000, hall_reg};
        `MDP_OFS_HALL_STAT: rd_next = {20'h00000, hall_out};
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_PER:  rd_next = 32'(per_reg[0]);
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY: rd_next = 32'(duty_reg[0]);
        `MDP_OFS_PULSE_WIDTH_OUT_TWO_PER:  rd_next = 32'(per_reg[1]);
        `MDP_OFS_PULSE_WIDTH_OUT_TWO_DUTY: rd_next = 32'(duty_reg[1]);
        `MDP_OFS_PWM_CLK:   rd_next = {31'h00000000, pwm_ext_reg};
        `MDP_OFS_TRIG_MODE: rd_next = {16'h0000, trig_mode_reg};
        `MDP_OFS_TRIG_SEL:  rd_next = {8'h00, trig_sel_reg};
        `MDP_OFS_TRIG_DOUT: rd_next = {24'h000000, tdio_out_reg};
        `MDP_OFS_TRIG_DIR:  rd_next = {24'h000000, tdio_dir_reg};
        `MDP_OFS_TRIG_STAT: rd_next = {23'h000000, star_s2_reg, trig_s2_reg};
        `MDP_OFS_DRV_MODE:  rd_next = 32'(oc_reg);
        `MDP_OFS_PULL_STAT: rd_next = {30'h00000000, pull_up_out};
        default:            rd_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
    end else begin
      rdata_out <= rd_in ? rd_next : 32'h00000000;
    end
  end

endmodule : mdp_router

//--- sim/mdp_pins_model.sv
// Far side of the pins: outside drivers, pull resistors, trigger bus and PWM clock.
// Assumes the bench says which lines outside parties drive and when the clock runs.
`timescale 1ns/100ps
module mdp_pins_model (
  input  wire logic        clock_in,
  input  wire logic [63:0] gpio_drv_in,
  input  wire logic [63:0] gpio_oe_in,
  input  wire logic [1:0]  pull_in,
  input  wire logic [63:0] ext_en_in,
  input  wire logic [63:0] ext_val_in,
  input  wire logic [7:0]  trg_drv_in,
  input  wire logic [7:0]  trg_oe_in,
  input  wire logic [7:0]  trg_en_in,
  input  wire logic [7:0]  trg_val_in,
  input  wire logic        pclk_run_in,
  output logic      [63:0] pin_out,
  output logic      [7:0]  trg_pin_out,
  output logic             pclk_out
);
  logic [63:0] pull_lvl;
  logic        noise_q = 1'b0;

  // Undriven lines rest at the pull level of their group of four ports.
  assign pull_lvl = {{32{pull_in[1]}}, {32{pull_in[0]}}};
  assign pin_out  = (gpio_oe_in & gpio_drv_in) | (~gpio_oe_in & ext_en_in & ext_val_in)
                  | (~gpio_oe_in & ~ext_en_in & pull_lvl);
  // Undriven trigger lines have no pull, so they show a changing level.
  assign trg_pin_out = (trg_oe_in & trg_drv_in) | (~trg_oe_in & trg_en_in & trg_val_in)
                     | (~trg_oe_in & ~trg_en_in & {8{noise_q}});

  always @(posedge clock_in) begin
    noise_q <= ~noise_q;
  end

  // External PWM clock of three system periods, still while not running.
  initial begin
    pclk_out = 1'b0;
    #7;
    forever begin
      #60;
      pclk_out = pclk_run_in ? ~pclk_out : 1'b0;
    end
  end
endmodule : mdp_pins_model

//--- sim/mdp_router_checker.sv
// Port checker for the I/O router: shadows writes and checks outputs against them.
// Assumes it is bound to mdp_router and shares its clock and reset.
`timescale 1ns/100ps
`include "mdp_defs.svh"
module mdp_router_checker
  import mdp_pkg::*;
#(
  parameter int NUM_AXES = 8
) (
  input wire logic                clock_in,
  input wire logic                rst_n_in,
  input wire logic [7:0]          addr_in,
  input wire logic [31:0]         wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [31:0]         rdata_out,
  input wire logic [63:0]         gpio_out,
  input wire logic [63:0]         gpio_oe_out,
  input wire logic [1:0]          pull_up_out,
  input wire logic                pulse_width_out_one_out,
  input wire logic [7:0]          sync_trigger_bus_in,
  input wire logic [7:0]          sync_trigger_bus_out,
  input wire logic [7:0]          sync_trigger_bus_oe_out,
  input wire logic [7:0]          capture_trigger_out,
  input wire logic [7:0]          breakpoint_event_in,
  input wire logic [7:0]          encoder_filtered_in,
  input wire logic [NUM_AXES-1:0] step_gen_in,
  input wire logic [NUM_AXES-1:0] dir_gen_in,
  input wire logic [NUM_AXES-1:0] step_out,
  input wire logic [NUM_AXES-1:0] step_oe_out,
  input wire logic [NUM_AXES-1:0] dir_out,
  input wire logic [NUM_AXES-1:0] dir_oe_out
);
  logic [2:0]          up_cnt;
  logic [2:0]          since_ev;
  logic [15:0]         mode_q;
  logic [23:0]         sel_q;
  logic [NUM_AXES-1:0] oc_q;
  logic [3:0]          hall_q;
  logic [15:0]         duty1_q;
  logic [15:0]         per1_q;
  logic [63:0]         hall_mask;
  logic                ev0;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  assign ev0       = breakpoint_event_in[sel_q[2:0]];
  assign hall_mask = {{3{hall_q[3]}}, {3{hall_q[2]}}, 26'h0, {3{hall_q[1]}}, {3{hall_q[0]}},
                      26'h0};

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      up_cnt   <= 3'h0;
      since_ev <= 3'h7;
    end else begin
      up_cnt   <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
      since_ev <= ev0 ? 3'h0 : ((since_ev == 3'h7) ? since_ev : since_ev + 3'h1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      mode_q  <= '0;
      sel_q   <= '0;
      oc_q    <= '0;
      hall_q  <= '0;
      duty1_q <= '0;
      per1_q  <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `MDP_OFS_TRIG_MODE: mode_q <= wdata_in[15:0];
        `MDP_OFS_TRIG_SEL:  sel_q <= wdata_in[23:0];
        `MDP_OFS_DRV_MODE:  oc_q <= wdata_in[NUM_AXES-1:0];
        `MDP_OFS_HALL_CFG:  hall_q <= hall_q | wdata_in[3:0];
        `MDP_OFS_REINIT:    hall_q <= 4'h0;
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_PER:  per1_q <= wdata_in[15:0];
        `MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY: duty1_q <= wdata_in[15:0];
        default: ;
      endcase
    end
  end

  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside its cycle");
  bp_pulse_a: assert property (mode_q[1:0] == 2'h1 && ev0 |=> sync_trigger_bus_out[0] [*5])
    else $error("compare pulse shorter than five cycles");
  bp_gap_a: assert property (mode_q[1:0] == 2'h1 && $past(mode_q[1:0]) == 2'h1 &&
    since_ev >= 3'h5 |-> !sync_trigger_bus_out[0]) else $error("compare pulse too long");
  route_oe_a: assert property (mode_q[1:0] != 2'h3 |=>
    sync_trigger_bus_oe_out[0] == ($past(mode_q[1:0]) != 2'h0)) else $error("trigger enable");
  enc_follow_a: assert property (mode_q[3:2] == 2'h2 |=> sync_trigger_bus_oe_out[1] &&
    sync_trigger_bus_out[1] == $past(encoder_filtered_in[sel_q[5:3]]))
    else $error("encoder routing");
  cap_follow_a: assert property (up_cnt >= 3'h4 && $past(mode_q[7:6]) == 2'h0 |->
    capture_trigger_out[3] == $past(sync_trigger_bus_in[3], 3)) else $error("capture level");
  drv_mode_a: assert property (up_cnt >= 3'h2 |->
    step_out == $past(step_gen_in & ~oc_q) && step_oe_out == ~$past(step_gen_in & oc_q) &&
    dir_out == $past(dir_gen_in & ~oc_q) && dir_oe_out == ~$past(dir_gen_in & oc_q))
    else $error("driver mode");
  hall_block_a: assert property (hall_q != 4'h0 |=>
    ((gpio_oe_out | gpio_out) & $past(hall_mask)) == 64'h0) else $error("Hall bit driven");
  pwm_zero_a: assert property ($past(duty1_q) == 16'h0 |-> !pulse_width_out_one_out)
    else $error("pulse output high with zero duty");
  pwm_full_a: assert property ($past(duty1_q) != 16'h0 &&
    $past(duty1_q) >= $past(per1_q) |-> pulse_width_out_one_out) else $error("full duty");
  pull_keep_a: assert property (up_cnt >= 3'h2 |-> $stable(pull_up_out))
    else $error("pull selection changed");

  bp_seen_c: cover property (mode_q[1:0] == 2'h1 && ev0);
  hall_seen_c: cover property (hall_q != 4'h0);
  pwm_rise_c: cover property ($rose(pulse_width_out_one_out));
endmodule : mdp_router_checker

bind mdp_router mdp_router_checker #(.NUM_AXES(NUM_AXES)) u_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gpio_out(gpio_out),
  .gpio_oe_out(gpio_oe_out), .pull_up_out(pull_up_out),
  .pulse_width_out_one_out(pulse_width_out_one_out),
  .sync_trigger_bus_in(sync_trigger_bus_in), .sync_trigger_bus_out(sync_trigger_bus_out),
  .sync_trigger_bus_oe_out(sync_trigger_bus_oe_out),
  .capture_trigger_out(capture_trigger_out), .breakpoint_event_in(breakpoint_event_in),
  .encoder_filtered_in(encoder_filtered_in), .step_gen_in(step_gen_in),
  .dir_gen_in(dir_gen_in), .step_out(step_out), .step_oe_out(step_oe_out),
  .dir_out(dir_out), .dir_oe_out(dir_oe_out));

//--- sim/mdp_router_tb_top.sv
// Self-checking bench for the I/O router with a pin model at its far side.
// Assumes the register map and timing of the router's strobe register port.
`timescale 1ns/100ps
`include "mdp_defs.svh"
module mdp_router_tb_top
  import mdp_pkg::*;
;
  logic clock_in, rst_n_in, wr_in, rd_in, pclk, pclk_run, star, pulse_width_out_one, pulse_width_out_two, star_cap, trg_clr;
  logic [7:0]  addr_in, trg_in, trg_out, trg_oe, trg_en, trg_val, cap, bp, enc, v, p;
  logic [7:0]  st_o, st_oe, dr_o, dr_oe, st_gen, dr_gen;
  logic [31:0] wdata_in, rdata_out, d;
  logic [63:0] gin, gout, goe, ext_en, ext_val, h, trg_hi;
  logic [1:0]  pull_sel, pull_up;
  logic [11:0] hall;
  int          bad_count, samples_checked, cycles;

  mdp_router #(.PWM_W(16), .NUM_AXES(8)) DUT (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gpio_in(gin), .gpio_out(gout),
    .gpio_oe_out(goe), .power_up_pull_select_in(pull_sel), .pull_up_out(pull_up),
    .hall_out(hall), .pwm_ext_clk_in(pclk), .pulse_width_out_one_out(pulse_width_out_one),
    .pulse_width_out_two_out(pulse_width_out_two), .sync_trigger_bus_in(trg_in),
    .sync_trigger_bus_out(trg_out), .sync_trigger_bus_oe_out(trg_oe), .star_trigger_in(star),
    .capture_trigger_out(cap), .star_capture_out(star_cap), .breakpoint_event_in(bp),
    .encoder_filtered_in(enc), .step_gen_in(st_gen), .dir_gen_in(dr_gen), .step_out(st_o),
    .step_oe_out(st_oe), .dir_out(dr_o), .dir_oe_out(dr_oe));

  mdp_pins_model u_pins (
    .clock_in(clock_in), .gpio_drv_in(gout), .gpio_oe_in(goe), .pull_in(pull_up),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .trg_drv_in(trg_out), .trg_oe_in(trg_oe),
    .trg_en_in(trg_en), .trg_val_in(trg_val), .pclk_run_in(pclk_run), .pin_out(gin),
    .trg_pin_out(trg_in), .pclk_out(pclk));

  always #20 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    cycles++;
    if (trg_clr) trg_hi <= 64'h0;
    else if (trg_out[0]) trg_hi <= trg_hi + 64'h1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= x;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
    chk(d, e);
  endtask : rd_chk

  task automatic count_pwm(input logic two, input int n);
    h = 64'h0;
    repeat (n) begin
      @(posedge clock_in);
      #1;
      if (two ? pulse_width_out_two : pulse_width_out_one) h = h + 64'h1;
    end
  endtask : count_pwm

  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  initial begin
    clock_in = 1'b0; rst_n_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 8'h00;
    wdata_in = 32'h0; pull_sel = 2'h1; star = 1'b0; bp = 8'h00; enc = 8'h00;
    st_gen = 8'h00; dr_gen = 8'h00; ext_en = 64'h0; ext_val = 64'h0; trg_en = 8'h00;
    trg_val = 8'h00; pclk_run = 1'b0; trg_clr = 1'b1;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    cyc(4);
    chk(pull_up, 2'h1);
    chk(goe, 64'h0);
    rd_chk(`MDP_OFS_PULL_STAT, 32'h1);
    for (p = 8'h0; p < 8'h8; p++) begin
      rd_chk(`MDP_OFS_PORT_DIR + p, 32'h0);
      rd_chk(`MDP_OFS_PORT_POL + p, 32'h0);
      rd_chk(`MDP_OFS_PORT_DATA + p, (p < 8'h4) ? 32'hFF : 32'h0);
      v = 8'hA5 ^ p;
      wr(`MDP_OFS_PORT_DIR + p, 32'hFF);
      wr(`MDP_OFS_PORT_DATA + p, {24'h0, v});
      cyc(3);
      chk({goe[p*8 +: 8], gout[p*8 +: 8]}, {8'hFF, v});
      wr(`MDP_OFS_PORT_POL + p, 32'hFF);
      cyc(3);
      chk(gout[p*8 +: 8], {~v});
      rd_chk(`MDP_OFS_PORT_DATA + p, {24'h0, v});
      wr(`MDP_OFS_PORT_DIR + p, 32'h0);
      ext_en[p*8 +: 8]  <= 8'hFF;
      ext_val[p*8 +: 8] <= v;
      cyc(4);
      rd_chk(`MDP_OFS_PORT_DATA + p, {24'h0, ~v});
      ext_en <= 64'h0;
      wr(`MDP_OFS_PORT_POL + p, 32'h0);
    end
    wr(`MDP_OFS_PORT_DIR + 8'h3, 32'hFF);
    wr(`MDP_OFS_PORT_DATA + 8'h3, 32'hFF);
    wr(`MDP_OFS_PORT_DIR + 8'h7, 32'hFF);
    wr(`MDP_OFS_HALL_CFG, 32'h9);
    wr(`MDP_OFS_HALL_CFG, 32'h0);
    ext_en  <= 64'hE000_0000_1C00_0000;
    ext_val <= 64'h6000_0000_1400_0000;
    cyc(6);
    chk({goe[63:56], goe[31:24]}, 16'h1FE3);
    chk(hall, 12'h605);
    rd_chk(`MDP_OFS_HALL_STAT, 32'h605);
    rd_chk(`MDP_OFS_PORT_DATA + 8'h3, 32'hE3);
    wr(`MDP_OFS_REINIT, 32'h0);
    cyc(3);
    chk(goe, 64'h0);
    rd_chk(`MDP_OFS_HALL_STAT, 32'h0);
    ext_en <= 64'h0;
    wr(`MDP_OFS_PULSE_WIDTH_OUT_ONE_PER, 32'hA);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY, 32'h3);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_TWO_PER, 32'h8);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_TWO_DUTY, 32'h4);
    cyc(30);
    count_pwm(1'b0, 10);
    chk(h, 64'h3);
    count_pwm(1'b1, 8);
    chk(h, 64'h4);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY, 32'h0);
    cyc(20);
    count_pwm(1'b0, 10);
    chk(h, 64'h0);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY, 32'hC);
    cyc(20);
    count_pwm(1'b0, 10);
    chk(h, 64'hA);
    wr(`MDP_OFS_PULSE_WIDTH_OUT_ONE_DUTY, 32'h3);
    pclk_run <= 1'b1;
    wr(`MDP_OFS_PWM_CLK, 32'h1);
    cyc(100);
    count_pwm(1'b0, 30);
    chk(h, 64'h9);
    pclk_run <= 1'b0;
    wr(`MDP_OFS_TRIG_SEL, 32'h10);
    wr(`MDP_OFS_TRIG_MODE, {24'h0, MDP_TRG_CAPTURE_IN, MDP_TRG_GENERIC_DIO,
       MDP_TRG_ENCODER_OUT, MDP_TRG_BREAKPOINT_OUT});
    wr(`MDP_OFS_TRIG_DOUT, 32'h4);
    wr(`MDP_OFS_TRIG_DIR, 32'h4);
    trg_en  <= 8'hF8;
    trg_val <= 8'h08;
    star    <= 1'b1;
    enc     <= 8'h04;
    cyc(5);
    chk({trg_oe[3:0], trg_out[2:0]}, 7'h3E);
    chk({star_cap, cap[3:0]}, 5'h18);
    rd_chk(`MDP_OFS_TRIG_STAT, 32'h10E);
    enc <= 8'h03;
    cyc(3);
    chk(trg_out[1], 1'b0);
    trg_clr <= 1'b1;
    @(posedge clock_in);
    bp <= 8'h01;
    trg_clr <= 1'b0;
    @(posedge clock_in);
    bp <= 8'h00;
    cyc(10);
    chk(trg_hi, 64'h5);
    trg_clr <= 1'b1;
    @(posedge clock_in);
    bp <= 8'h01;
    trg_clr <= 1'b0;
    @(posedge clock_in);
    bp <= 8'h00;
    @(posedge clock_in);
    bp <= 8'h01;
    @(posedge clock_in);
    bp <= 8'h00;
    cyc(12);
    chk(trg_hi, 64'h7);
    wr(`MDP_OFS_DRV_MODE, 32'h1);
    st_gen <= 8'h03;
    dr_gen <= 8'h01;
    cyc(3);
    chk({st_o, st_oe, dr_o, dr_oe}, 32'h02FE00FE);
    wr(8'h7F, 32'hFFFFFFFF);
    rd_chk(8'h7F, 32'h0);
    close_out();
  end
endmodule : mdp_router_tb_top
